// >>> odcr_pkg.sv
// Package for the command register bank: codes, field positions, reset values
`default_nettype none
package odcr_pkg;
  // ==========================================================================
  // Command codes (upper byte of the command word)
  localparam logic [7:0] CMD_CLK_DIV     = 8'h00;
  localparam logic [7:0] CMD_BRIGHT_A    = 8'h01;
  localparam logic [7:0] CMD_BRIGHT_B    = 8'h02;
  localparam logic [7:0] CMD_BOOST_CTRL  = 8'h03;
  localparam logic [7:0] CMD_BOOST_OFS   = 8'h06;
  localparam logic [7:0] CMD_DISP_CTRL   = 8'h10;
  // ==========================================================================
  // Field positions within the data byte
  localparam int DIV_LSB      = 0;
  localparam int DIV_W        = 3;
  localparam int ADJ_LSB      = 0;
  localparam int ADJ_W        = 7;
  localparam int ADJ_SEL_BIT  = 7;
  localparam int BOOST_EN_BIT = 0;
  localparam int LOOP_REF_BIT = 1;
  localparam int FREQ_LSB     = 2;
  localparam int FREQ_W       = 2;
  localparam int OFS_LSB      = 0;
  localparam int OFS_W        = 3;
  localparam int PANEL_ON_BIT = 0;
  localparam int ALL_LIT_BIT  = 1;
  localparam int REVERSAL_BIT = 2;
  // ==========================================================================
  // Reset values
  localparam logic [2:0] DIV_RST  = 3'h0;
  localparam logic [6:0] ADJ_RST  = 7'h00;
  localparam logic [1:0] FREQ_RST = 2'h0;
  localparam logic [2:0] OFS_RST  = 3'h0;
  localparam logic [6:0] DIV_CNT_RST = 7'h00;
endpackage
`default_nettype wire

// >>> odcr_regs.sv
// Write-only command register bank with clock divider and display pixel path
//
// Notes on behaviour
// [R01] Divide system clock by two to code power
// [R02] Hold seven-bit first adjust value, reset zero
// [R03] First select bit: zero fuse, one register
// [R04] Second adjust value and select, same behaviour
// [R05] Boost enable bit resets zero, one enables
// [R06] Loop reference: zero feedback, one bandgap
// [R07] Two-bit boost frequency code, default zero
// [R08] Three-bit boost offset code, default zero
// [R09] Panel off: outputs grounded, scanning stopped
// [R10] Panel off never forces boost converter off
// [R11] All-lit forces pixels on while panel on
// [R12] Reversal inverts display data on readout
// [R13] Command word: code high byte, data low
// [R14] Write-only; unknown codes change nothing
`timescale 1ns/10ps
`default_nettype none
module odcr_regs (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // Command word from the host port
  input  wire logic       CMD_VALID,
  input  wire logic [15:0] CMD_WORD,
  // Brightness fused values
  input  wire logic [6:0] FUSE_ADJ_FIRST,
  input  wire logic [6:0] FUSE_ADJ_SECOND,
  // Display data read from RAM
  input  wire logic       RAM_PIXEL,
  // Divided system clock tick
  output logic            SCLK_TICK,
  // Brightness converter inputs
  output logic [6:0]      ADJ_FIRST_CODE,
  output logic [6:0]      ADJ_SECOND_CODE,
  // Step-up converter controls
  output logic            BOOST_ENABLE,
  output logic            LOOP_REFERENCE_SEL,
  output logic [1:0]      BOOST_FREQUENCY_SEL,
  output logic [2:0]      OFFSET_VOLTAGE_CODE,
  // Panel drive
  output logic            SCAN_ENABLE,
  output logic            PIXEL_DRIVE
);

  logic [7:0] cmd_code;
  logic [7:0] cmd_data;
  logic [2:0] div_code_r;
  logic [6:0] adj_first_r;
  logic [6:0] adj_second_r;
  logic       sel_first_r;
  logic       sel_second_r;
  logic       boost_en_r;
  logic       loop_ref_r;
  logic [1:0] freq_r;
  logic [2:0] ofs_r;
  logic       panel_on_r;
  logic       all_lit_r;
  logic       reversal_r;
  logic [6:0] div_cnt_r;
  logic [6:0] div_cnt_nxt;
  logic [6:0] div_mask;

  // ==========================================================================
  // Command decode
  // No read path exists; the bank is write-only by construction
  // Split the word into code and data
  assign cmd_code = CMD_WORD[15:8]; // R13
  assign cmd_data = CMD_WORD[7:0]; // R13

  // Strobe for one code; any other code falls through and writes nothing
  // Valid and code are both required, so an idle bus holding a stale word
  // cannot rewrite a register
  function automatic logic hit(input logic v, input logic [7:0] c, input logic [7:0] k);
    hit = v && (c == k); // R14
  endfunction

  // Source pick for one brightness converter; both channels share it so
  // the fused/register priority cannot drift between them
  function automatic logic [6:0] pick_adj(input logic       s,
                                          input logic [6:0] r,
                                          input logic [6:0] f);
    pick_adj = s ? r : f; // R03 R04
  endfunction

  // ==========================================================================
  // Registers
  // Each register keeps its value until the same code is written again;
  // fixed-zero data bits are dropped rather than checked, so a host that
  // sets them by mistake still lands the defined fields
  // Clock divider code
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_code_r <= odcr_pkg::DIV_RST;
    end else if (hit(CMD_VALID, cmd_code, odcr_pkg::CMD_CLK_DIV)) begin
      div_code_r <= cmd_data[odcr_pkg::DIV_LSB +: odcr_pkg::DIV_W]; // R01
    end
  end

  // First brightness adjustment
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      adj_first_r <= odcr_pkg::ADJ_RST;
      sel_first_r <= 1'b0;
    end else if (hit(CMD_VALID, cmd_code, odcr_pkg::CMD_BRIGHT_A)) begin
      adj_first_r <= cmd_data[odcr_pkg::ADJ_LSB +: odcr_pkg::ADJ_W]; // R02
      sel_first_r <= cmd_data[odcr_pkg::ADJ_SEL_BIT]; // R03
    end
  end

  // Second brightness adjustment
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      adj_second_r <= odcr_pkg::ADJ_RST;
      sel_second_r <= 1'b0;
    end else if (hit(CMD_VALID, cmd_code, odcr_pkg::CMD_BRIGHT_B)) begin
      adj_second_r <= cmd_data[odcr_pkg::ADJ_LSB +: odcr_pkg::ADJ_W]; // R04
      sel_second_r <= cmd_data[odcr_pkg::ADJ_SEL_BIT]; // R04
    end
  end

  // Step-up converter control
  // Enable, reference and frequency arrive in one word and change together
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      boost_en_r <= 1'b0;
      loop_ref_r <= 1'b0;
      freq_r     <= odcr_pkg::FREQ_RST;
    end else if (hit(CMD_VALID, cmd_code, odcr_pkg::CMD_BOOST_CTRL)) begin
      boost_en_r <= cmd_data[odcr_pkg::BOOST_EN_BIT]; // R05
      loop_ref_r <= cmd_data[odcr_pkg::LOOP_REF_BIT]; // R06
      freq_r     <= cmd_data[odcr_pkg::FREQ_LSB +: odcr_pkg::FREQ_W]; // R07
    end
  end

  // Boost offset code
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ofs_r <= odcr_pkg::OFS_RST;
    end else if (hit(CMD_VALID, cmd_code, odcr_pkg::CMD_BOOST_OFS)) begin
      ofs_r <= cmd_data[odcr_pkg::OFS_LSB +: odcr_pkg::OFS_W]; // R08
    end
  end

  // Display control
  // Panel off grounds the drive but leaves the converter untouched
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      panel_on_r <= 1'b0;
      all_lit_r  <= 1'b0;
      reversal_r <= 1'b0;
    end else if (hit(CMD_VALID, cmd_code, odcr_pkg::CMD_DISP_CTRL)) begin
      panel_on_r <= cmd_data[odcr_pkg::PANEL_ON_BIT]; // R09
      all_lit_r  <= cmd_data[odcr_pkg::ALL_LIT_BIT]; // R11
      reversal_r <= cmd_data[odcr_pkg::REVERSAL_BIT]; // R12
    end
  end

  // ==========================================================================
  // Clock divider
  // Free counter; the tick fires when the low code bits are all zero,
  // so a ratio change takes effect without restarting the count
  // Limitation: the first tick after a ratio change may come early, since
  // the count is not cleared; a user needing a clean phase must reset the
  // block before choosing the ratio
  assign div_mask    = 7'((8'h01 << div_code_r) - 8'h01); // R01
  assign div_cnt_nxt = div_cnt_r + 7'h01;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_r <= odcr_pkg::DIV_CNT_RST;
      SCLK_TICK <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      SCLK_TICK <= ((div_cnt_nxt & div_mask) == 7'h00); // R01
    end
  end

  // ==========================================================================
  // Registered outputs
  // One register stage on every output keeps the pins glitch-free, at the
  // cost of one cycle of latency after the command edge
  // Converter inputs and controls; boost enable ignores panel state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ADJ_FIRST_CODE      <= odcr_pkg::ADJ_RST;
      ADJ_SECOND_CODE     <= odcr_pkg::ADJ_RST;
      BOOST_ENABLE        <= 1'b0;
      LOOP_REFERENCE_SEL  <= 1'b0;
      BOOST_FREQUENCY_SEL <= odcr_pkg::FREQ_RST;
      OFFSET_VOLTAGE_CODE <= odcr_pkg::OFS_RST;
    end else begin
      ADJ_FIRST_CODE      <= pick_adj(sel_first_r, adj_first_r, FUSE_ADJ_FIRST); // R03
      ADJ_SECOND_CODE     <= pick_adj(sel_second_r, adj_second_r, FUSE_ADJ_SECOND); // R04
      BOOST_ENABLE        <= boost_en_r; // R10
      LOOP_REFERENCE_SEL  <= loop_ref_r; // R06
      BOOST_FREQUENCY_SEL <= freq_r; // R07
      OFFSET_VOLTAGE_CODE <= ofs_r; // R08
    end
  end

  // Pixel path: off forces ground level, all-lit beats RAM, reversal inverts
  // Scan enable and pixel drive share one process so they never disagree
  // about the panel state, not even for one cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SCAN_ENABLE <= 1'b0;
      PIXEL_DRIVE <= 1'b0;
    end else begin
      SCAN_ENABLE <= panel_on_r; // R09
      if (!panel_on_r) begin
        PIXEL_DRIVE <= 1'b0; // R09
      end else if (all_lit_r) begin
        PIXEL_DRIVE <= 1'b1; // R11
      end else begin
        PIXEL_DRIVE <= RAM_PIXEL ^ reversal_r; // R12
      end
    end
  end

endmodule
`default_nettype wire

// >>> odcr_host.sv
// Host model that issues command words to the register bank
`timescale 1ns/10ps
`default_nettype none
module odcr_host (
  // Command port
  input  wire logic        CLK,
  output var  logic        CMD_VALID,
  output var  logic [15:0] CMD_WORD
);
  // ========
  // Idle word is the inverse of the last one, so a stale sample shows up
  initial begin
    CMD_VALID = 1'b0;
    CMD_WORD  = 16'hffff;
  end
  // One whole word per command, held across the taking edge
  task automatic send(input logic [15:0] w);
    @(posedge CLK);
    #1 CMD_VALID = 1'b1;
    CMD_WORD = w;
    @(posedge CLK);
    #1 CMD_VALID = 1'b0;
    CMD_WORD = ~w;
  endtask
endmodule
`default_nettype wire

// >>> odcr_regs_monitor.sv
// Concurrent checks on the command register bank ports
`timescale 1ns/10ps
`default_nettype none
module odcr_regs_monitor (
  // Clock, reset and inputs
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CMD_VALID,
  input wire logic [15:0] CMD_WORD,
  input wire logic [6:0]  FUSE_ADJ_FIRST,
  input wire logic [6:0]  FUSE_ADJ_SECOND,
  input wire logic        RAM_PIXEL,
  // Outputs under watch
  input wire logic [6:0]  ADJ_FIRST_CODE,
  input wire logic [6:0]  ADJ_SECOND_CODE,
  input wire logic        BOOST_ENABLE,
  input wire logic        LOOP_REFERENCE_SEL,
  input wire logic [1:0]  BOOST_FREQUENCY_SEL,
  input wire logic [2:0]  OFFSET_VOLTAGE_CODE,
  input wire logic        SCAN_ENABLE,
  input wire logic        PIXEL_DRIVE
);
  // ========
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [2:0] disp_r;
  // Mirror of the display bits; the pixel path cannot be judged without it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) disp_r <= 3'h0;
    else if (CMD_VALID && CMD_WORD[15:8] == 8'h10) disp_r <= CMD_WORD[2:0];
  end
  a_boost_ctrl: assert property (CMD_VALID && CMD_WORD[15:8] == 8'h03 |-> ##2
    {BOOST_FREQUENCY_SEL, LOOP_REFERENCE_SEL, BOOST_ENABLE} == $past(CMD_WORD[3:0], 2))
    else $error("boost control mismatch");
  a_offset_code: assert property (CMD_VALID && CMD_WORD[15:8] == 8'h06 |-> ##2
    OFFSET_VOLTAGE_CODE == $past(CMD_WORD[2:0], 2)) else $error("offset code mismatch");
  a_first_adj: assert property (CMD_VALID && CMD_WORD[15:8] == 8'h01 |-> ##2
    ADJ_FIRST_CODE == ($past(CMD_WORD[7], 2) ? $past(CMD_WORD[6:0], 2) : $past(FUSE_ADJ_FIRST)))
    else $error("first adjust mismatch");
  a_second_adj: assert property (CMD_VALID && CMD_WORD[15:8] == 8'h02 |-> ##2
    ADJ_SECOND_CODE == ($past(CMD_WORD[7], 2) ? $past(CMD_WORD[6:0], 2) : $past(FUSE_ADJ_SECOND)))
    else $error("second adjust mismatch");
  a_boost_hold: assert property (!($past(CMD_VALID, 2) && $past(CMD_WORD[15:8], 2) == 8'h03)
    |-> $stable(BOOST_ENABLE)) else $error("boost enable moved");
  a_dark_off: assert property (!$past(disp_r[0]) |-> !PIXEL_DRIVE)
    else $error("pixel lit while off");
  a_scan_follow: assert property (SCAN_ENABLE == $past(disp_r[0])) else $error("scan mismatch");
  a_pixel_path: assert property (PIXEL_DRIVE ==
    $past(disp_r[0] & (disp_r[1] | (RAM_PIXEL ^ disp_r[2])))) else $error("pixel mismatch");
endmodule
bind odcr_regs odcr_regs_monitor i_mon (
  .CLK                 (CLK),
  .RST_N               (RST_N),
  .CMD_VALID           (CMD_VALID),
  .CMD_WORD            (CMD_WORD),
  .FUSE_ADJ_FIRST      (FUSE_ADJ_FIRST),
  .FUSE_ADJ_SECOND     (FUSE_ADJ_SECOND),
  .RAM_PIXEL           (RAM_PIXEL),
  .ADJ_FIRST_CODE      (ADJ_FIRST_CODE),
  .ADJ_SECOND_CODE     (ADJ_SECOND_CODE),
  .BOOST_ENABLE        (BOOST_ENABLE),
  .LOOP_REFERENCE_SEL  (LOOP_REFERENCE_SEL),
  .BOOST_FREQUENCY_SEL (BOOST_FREQUENCY_SEL),
  .OFFSET_VOLTAGE_CODE (OFFSET_VOLTAGE_CODE),
  .SCAN_ENABLE         (SCAN_ENABLE),
  .PIXEL_DRIVE         (PIXEL_DRIVE)
);
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the command register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ========
  logic        CLK, RST_N, RAM_PIXEL, CMD_VALID, SCLK_TICK, BOOST_ENABLE;
  logic        LOOP_REFERENCE_SEL, SCAN_ENABLE, PIXEL_DRIVE;
  logic [15:0] CMD_WORD;
  logic [6:0]  ADJ_FIRST_CODE, ADJ_SECOND_CODE;
  logic [1:0]  BOOST_FREQUENCY_SEL;
  logic [2:0]  OFFSET_VOLTAGE_CODE;
  logic [6:0]  FUSE_ADJ_FIRST = 7'h2a;
  logic [6:0]  FUSE_ADJ_SECOND = 7'h55;
  int          mismatches = 0;
  int          num_checks = 0;
  odcr_host i_host (.CLK(CLK), .CMD_VALID(CMD_VALID), .CMD_WORD(CMD_WORD));
  odcr_regs i_dut (
    .CLK                 (CLK),
    .RST_N               (RST_N),
    .CMD_VALID           (CMD_VALID),
    .CMD_WORD            (CMD_WORD),
    .FUSE_ADJ_FIRST      (FUSE_ADJ_FIRST),
    .FUSE_ADJ_SECOND     (FUSE_ADJ_SECOND),
    .RAM_PIXEL           (RAM_PIXEL),
    .SCLK_TICK           (SCLK_TICK),
    .ADJ_FIRST_CODE      (ADJ_FIRST_CODE),
    .ADJ_SECOND_CODE     (ADJ_SECOND_CODE),
    .BOOST_ENABLE        (BOOST_ENABLE),
    .LOOP_REFERENCE_SEL  (LOOP_REFERENCE_SEL),
    .BOOST_FREQUENCY_SEL (BOOST_FREQUENCY_SEL),
    .OFFSET_VOLTAGE_CODE (OFFSET_VOLTAGE_CODE),
    .SCAN_ENABLE         (SCAN_ENABLE),
    .PIXEL_DRIVE         (PIXEL_DRIVE)
  );
  // Free-running 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Outputs are settled one edge after the command is taken
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    i_host.send({code, data});
    @(posedge CLK);
    #1;
  endtask
  // Counts cycles to the next tick; a missing tick ends the run
  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge CLK);
      #1 n++;
    end while (SCLK_TICK !== 1'b1 && n < 300);
    if (SCLK_TICK !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask
  task automatic t_reset;
    chk(8'(ADJ_FIRST_CODE), 8'h2a);
    chk(8'(ADJ_SECOND_CODE), 8'h55);
    chk(8'({BOOST_FREQUENCY_SEL, LOOP_REFERENCE_SEL, BOOST_ENABLE}), 8'h00);
    chk(8'({OFFSET_VOLTAGE_CODE, SCAN_ENABLE, PIXEL_DRIVE}), 8'h00);
  endtask
  task automatic t_adjust;
    wr(8'h01, 8'hff);
    chk(8'(ADJ_FIRST_CODE), 8'h7f);
    wr(8'h01, 8'h7f);
    chk(8'(ADJ_FIRST_CODE), 8'h2a);
    wr(8'h02, 8'h80);
    chk(8'(ADJ_SECOND_CODE), 8'h00);
    chk(8'(ADJ_FIRST_CODE), 8'h2a);
  endtask
  // Every control code, ending with the converter enabled
  task automatic t_boost;
    for (int i = 0; i < 8; i++) begin
      wr(8'h06, 8'(i));
      chk(8'(OFFSET_VOLTAGE_CODE), 8'(i));
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h03, 8'(i));
      chk(8'({BOOST_FREQUENCY_SEL, LOOP_REFERENCE_SEL, BOOST_ENABLE}), 8'(i));
    end
  endtask
  // Undefined codes carry data that would clear the controls if decoded
  task automatic t_unknown;
    logic [7:0] codes [4] = '{8'h04, 8'h05, 8'h11, 8'hff};
    foreach (codes[k]) wr(codes[k], 8'h00);
    chk(8'({OFFSET_VOLTAGE_CODE, BOOST_FREQUENCY_SEL, LOOP_REFERENCE_SEL, BOOST_ENABLE}), 8'h7f);
  endtask
  task automatic t_display;
    for (int m = 0; m < 8; m++) begin
      wr(8'h10, 8'(m));
      chk(8'(SCAN_ENABLE), 8'(m[0]));
      chk(8'(BOOST_ENABLE), 8'h01);
      for (int p = 0; p < 2; p++) begin
        RAM_PIXEL = p[0];
        @(posedge CLK);
        #1 chk(8'(PIXEL_DRIVE), 8'(m[0] & (m[1] | (p[0] ^ m[2]))));
      end
    end
    chk(8'(BOOST_ENABLE), 8'h01);
  endtask
  task automatic t_divider;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'(c));
      tick_gap(n);
      tick_gap(n);
      chk(8'(n), 8'(1 << c));
    end
  endtask
  // Reset, then each scenario in turn
  initial begin
    RST_N = 1'b0;
    RAM_PIXEL = 1'b0;
    repeat (5) @(posedge CLK);
    #1 RST_N = 1'b1;
    @(posedge CLK);
    #1 t_reset();
    t_adjust();
    t_boost();
    t_unknown();
    t_display();
    t_divider();
    results();
  end
endmodule
`default_nettype wire
